// ---- rtl/dbc_top.sv ----
// Breakpoint control, match and status logic of the debug facility
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns

// Function
// RULE1: Two-bit length per breakpoint: 1,2,4 bytes
// RULE2: Length 00 compares all 32 bits
// RULE3: Length 01 ignores address bit 0
// RULE4: Length 11 ignores address bits 1,0
// RULE5: Software never programs length 10
// RULE6: Access type: 00 exec, 01 write, 11 rdwr
// RULE7: Software never programs access type 10
// RULE8: Exec hit faults before; data hit traps after
// RULE9: Any data overlap on enabled breakpoint traps
// RULE10: Software sets exec breakpoints with 00,00
// RULE11: Exec hit only on instruction first byte
// RULE12: Register access only real mode or level 0
// RULE13: Guard bit faults any register access
// RULE14: Handler entry clears the guard bit
// RULE15: Data breakpoints exact; next instruction waits
// RULE16: Task switch clears local exact bit only
// RULE17: Task switch clears local enables only
// RULE18: Global or local enable; hit raises exception
// RULE19: One status flag per debug event
// RULE20: Status flags set by hardware, cleared by software
// RULE21: Handler should clear status before return
// RULE22: All breakpoints disabled after reset
// RULE23: Enabled hit flags every matching breakpoint
module dbc_top
  import dbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic real_mode,
  input wire logic [1:0] cpl,
  input wire logic instr_valid,
  input wire logic [31:0] instr_addr,
  input wire logic data_valid,
  input wire logic data_done,
  input wire logic [29:0] data_dword_addr,
  input wire logic [3:0] data_be,
  input wire logic data_write,
  input wire logic single_step,
  input wire logic task_trap,
  input wire logic task_switch,
  input wire logic handler_entry,
  output logic exc1_fault,
  output logic exc1_trap,
  output logic reg_access_fault,
  output logic exec_hold
);

  function automatic logic [31:0] dbc_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  dbc_bus_state_t state;
  dbc_bus_state_t next_state;

  logic [31:0] debug_control;
  logic [31:0] debug_status;
  logic [31:0] bp_linear_addr_reg [DBC_NUM_BP];

  logic [31:0] next_debug_control;
  logic [31:0] next_debug_status;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  // Bus decode
  wire bus_req = avs_read || avs_write;
  wire bus_accept = (state == DBC_BUS_IDLE) && bus_req;
  wire bus_commit = (state == DBC_BUS_ANSWER) && bus_req;
  wire sel_status = avs_address == DBC_OFF_STATUS;
  wire sel_control = avs_address == DBC_OFF_CONTROL;

  // Access permission
  wire priv_ok = real_mode || (cpl == 2'h0); // RULE12
  wire debug_reg_guard = debug_control[DBC_CTL_GUARD];
  wire access_ok = priv_ok && !debug_reg_guard;
  wire guard_fault = bus_commit && priv_ok && debug_reg_guard; // RULE13
  wire priv_fault = bus_commit && !priv_ok; // RULE12
  wire wr_en = bus_commit && avs_write && access_ok;
  wire ctrl_wr = wr_en && sel_control;
  wire status_wr = wr_en && sel_status;

  // Per-breakpoint decode and match
  logic [DBC_NUM_BP-1:0] bp_enable_global;
  logic [DBC_NUM_BP-1:0] bp_enable_local;
  logic [DBC_NUM_BP-1:0] bp_enabled;
  logic [DBC_NUM_BP-1:0] instr_hit;
  logic [DBC_NUM_BP-1:0] data_hit;
  logic [DBC_NUM_BP-1:0] addr_sel;
  logic [DBC_NUM_BP-1:0] addr_wr;

  genvar gi;
  generate
    for (gi = 0; gi < DBC_NUM_BP; gi++) begin : g_bp
      logic [1:0] bp_length_field;
      logic [1:0] bp_access_type;

      assign bp_length_field = debug_control[DBC_CTL_LENGTH0 + gi*DBC_CTL_BP_STRIDE +: 2]; // RULE1
      assign bp_access_type = debug_control[DBC_CTL_ACCESS0 + gi*DBC_CTL_BP_STRIDE +: 2]; // RULE6
      assign bp_enable_local[gi] = debug_control[DBC_CTL_LOCAL0 + gi*2];
      assign bp_enable_global[gi] = debug_control[DBC_CTL_GLOBAL0 + gi*2];
      assign bp_enabled[gi] = bp_enable_global[gi] || bp_enable_local[gi]; // RULE18
      assign addr_sel[gi] = avs_address == (DBC_OFF_ADDR0 + 5'(gi*4));
      assign addr_wr[gi] = wr_en && addr_sel[gi];

      dbc_bp_match u_match (
        .bp_addr(bp_linear_addr_reg[gi]),
        .bp_length_field(bp_length_field),
        .bp_access_type(bp_access_type),
        .instr_valid(instr_valid),
        .instr_addr(instr_addr),
        .data_done(data_done),
        .data_dword_addr(data_dword_addr),
        .data_be(data_be),
        .data_write(data_write),
        .instr_hit(instr_hit[gi]),
        .data_hit(data_hit[gi])
      );

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          bp_linear_addr_reg[gi] <= DBC_ADDR_RST;
        end else if (addr_wr[gi]) begin
          bp_linear_addr_reg[gi] <= dbc_merge(bp_linear_addr_reg[gi], avs_writedata, avs_byteenable);
        end
      end
    end
  endgenerate

  // Hits that actually raise the exception
  wire [DBC_NUM_BP-1:0] any_hit = instr_hit | data_hit;
  wire en_instr_hit = |(instr_hit & bp_enabled); // RULE18
  wire en_data_hit = |(data_hit & bp_enabled); // RULE9
  wire en_any_hit = en_instr_hit || en_data_hit;

  // Flags of all matching breakpoints, enabled or not, once an enabled one hits
  wire [DBC_NUM_BP-1:0] hit_set = en_any_hit ? any_hit : '0; // RULE23

  // Hardware set events on debug_status
  logic [31:0] status_set;
  always_comb begin
    status_set = 32'h0000_0000;
    status_set[DBC_STS_HIT0 +: DBC_NUM_BP] = hit_set; // RULE19
    status_set[DBC_STS_GUARD] = guard_fault; // RULE19
    status_set[DBC_STS_STEP] = single_step; // RULE19
    status_set[DBC_STS_TASK] = task_trap; // RULE19
  end

  // Set wins over a software clear in the same cycle
  always_comb begin
    next_debug_status = debug_status;
    if (status_wr) begin
      next_debug_status = dbc_merge(debug_status, avs_writedata, avs_byteenable) & DBC_STATUS_WMASK;
    end
    next_debug_status = next_debug_status | status_set; // RULE20
  end

  // Hardware clears win over a software write in the same cycle
  always_comb begin
    next_debug_control = debug_control;
    if (ctrl_wr) begin
      next_debug_control = dbc_merge(debug_control, avs_writedata, avs_byteenable) & DBC_CONTROL_WMASK;
    end
    if (task_switch) begin
      next_debug_control = next_debug_control & ~DBC_CONTROL_TS_CLR; // RULE16 RULE17
    end
    if (handler_entry) begin
      next_debug_control[DBC_CTL_GUARD] = 1'b0; // RULE14
    end
  end

  // Read data, gated by access permission
  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    for (int i = 0; i < DBC_NUM_BP; i++) begin
      if (addr_sel[i]) begin
        read_mux = bp_linear_addr_reg[i];
      end
    end
    if (sel_status) begin
      read_mux = debug_status;
    end
    if (sel_control) begin
      read_mux = debug_control;
    end
  end

  // Bus sequencing: one wait cycle, then the answer
  always_comb begin
    next_state = state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (state)
      DBC_BUS_IDLE: begin
        if (bus_accept) begin
          next_state = DBC_BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = (avs_read && access_ok) ? read_mux : 32'h0000_0000;
        end
      end
      DBC_BUS_ANSWER: begin
        next_state = DBC_BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_state = DBC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DBC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // Control comes out of reset with every enable clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_control <= DBC_CONTROL_RST; // RULE22
    end else begin
      debug_control <= next_debug_control;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_status <= DBC_STATUS_RST;
    end else begin
      debug_status <= next_debug_status;
    end
  end

  // Exception requests to the core
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exc1_fault <= 1'b0;
      exc1_trap <= 1'b0;
      reg_access_fault <= 1'b0;
    end else begin
      exc1_fault <= en_instr_hit || guard_fault; // RULE8 RULE13
      exc1_trap <= en_data_hit || single_step || task_trap; // RULE8 RULE9
      reg_access_fault <= priv_fault; // RULE12
    end
  end

  // Exact reporting is unconditional: exact-match bits do not gate it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_hold <= 1'b0;
    end else begin
      exec_hold <= data_valid && !data_done; // RULE15
    end
  end

endmodule

// ---- rtl/dbc_pkg.sv ----
// Package of constants and types for the debug breakpoint control block
package dbc_pkg;

  localparam int DBC_NUM_BP = 4;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] DBC_OFF_ADDR0 = 5'h00;
  localparam logic [4:0] DBC_OFF_ADDR1 = 5'h04;
  localparam logic [4:0] DBC_OFF_ADDR2 = 5'h08;
  localparam logic [4:0] DBC_OFF_ADDR3 = 5'h0c;
  localparam logic [4:0] DBC_OFF_STATUS = 5'h10;
  localparam logic [4:0] DBC_OFF_CONTROL = 5'h14;

  // Reset values
  localparam logic [31:0] DBC_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] DBC_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] DBC_ADDR_RST = 32'h0000_0000;

  // debug_control field positions
  localparam int DBC_CTL_LOCAL0 = 0;
  localparam int DBC_CTL_GLOBAL0 = 1;
  localparam int DBC_CTL_EXACT_LOCAL = 8;
  localparam int DBC_CTL_EXACT_GLOBAL = 9;
  localparam int DBC_CTL_GUARD = 13;
  localparam int DBC_CTL_ACCESS0 = 16;
  localparam int DBC_CTL_LENGTH0 = 18;
  localparam int DBC_CTL_BP_STRIDE = 4;
  localparam logic [31:0] DBC_CONTROL_WMASK = 32'hffff_23ff;
  localparam logic [31:0] DBC_CONTROL_TS_CLR = 32'h0000_0155;

  // debug_status field positions
  localparam int DBC_STS_HIT0 = 0;
  localparam int DBC_STS_GUARD = 13;
  localparam int DBC_STS_STEP = 14;
  localparam int DBC_STS_TASK = 15;
  localparam logic [31:0] DBC_STATUS_WMASK = 32'h0000_e00f;

  // Length and access-type encodings
  localparam logic [1:0] DBC_LEN_BYTE = 2'h0;
  localparam logic [1:0] DBC_LEN_WORD = 2'h1;
  localparam logic [1:0] DBC_LEN_DWORD = 2'h3;
  localparam logic [1:0] DBC_RW_EXEC = 2'h0;
  localparam logic [1:0] DBC_RW_WRITE = 2'h1;
  localparam logic [1:0] DBC_RW_UNDEF = 2'h2;
  localparam logic [1:0] DBC_RW_RDWR = 2'h3;

  localparam logic [31:0] DBC_MASK_BYTE = 32'hffff_ffff;
  localparam logic [31:0] DBC_MASK_WORD = 32'hffff_fffe;
  localparam logic [31:0] DBC_MASK_DWORD = 32'hffff_fffc;

  // Cycles from request to waitrequest low
  localparam int DBC_ANSWER_CYCLES = 1;

  typedef enum logic {
    DBC_BUS_IDLE,
    DBC_BUS_ANSWER
  } dbc_bus_state_t;

endpackage

// ---- rtl/dbc_bp_match.sv ----
// Match logic of one linear-address breakpoint
`timescale 1ns/1ns
module dbc_bp_match
  import dbc_pkg::*;
(
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] bp_length_field,
  input wire logic [1:0] bp_access_type,
  input wire logic instr_valid,
  input wire logic [31:0] instr_addr,
  input wire logic data_done,
  input wire logic [29:0] data_dword_addr,
  input wire logic [3:0] data_be,
  input wire logic data_write,
  output logic instr_hit,
  output logic data_hit
);

  logic [31:0] addr_mask;
  logic [3:0] field_be;
  logic is_data_type;
  logic dir_ok;
  logic dword_eq;

  // Undefined length 10 falls back to byte compare
  assign addr_mask = (bp_length_field == DBC_LEN_WORD) ? DBC_MASK_WORD : // RULE3 RULE5
                     (bp_length_field == DBC_LEN_DWORD) ? DBC_MASK_DWORD : // RULE4
                     DBC_MASK_BYTE; // RULE2

  assign field_be = (bp_length_field == DBC_LEN_DWORD) ? 4'hf :
                    (bp_length_field == DBC_LEN_WORD) ? (bp_addr[1] ? 4'hc : 4'h3) :
                    4'h1 << bp_addr[1:0];

  // Full 32-bit compare when length is byte, so only the first byte hits
  assign instr_hit = instr_valid && (bp_access_type == DBC_RW_EXEC) && // RULE11 RULE10
                     ((instr_addr & addr_mask) == (bp_addr & addr_mask));

  assign is_data_type = (bp_access_type != DBC_RW_EXEC) && (bp_access_type != DBC_RW_UNDEF); // RULE7
  assign dir_ok = data_write || (bp_access_type == DBC_RW_RDWR); // RULE6
  assign dword_eq = data_dword_addr == bp_addr[31:2];

  // Partial overlap of any enabled byte lane counts
  assign data_hit = data_done && is_data_type && dir_ok && dword_eq && |(data_be & field_be); // RULE9

endmodule

// ---- verif/dbc_top_properties.sv ----
// Port assertions for the breakpoint control block
`timescale 1ns/1ns
module dbc_top_properties
  import dbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic real_mode,
  input wire logic [1:0] cpl,
  input wire logic instr_valid,
  input wire logic data_valid,
  input wire logic data_done,
  input wire logic single_step,
  input wire logic task_trap,
  input wire logic exc1_fault,
  input wire logic exc1_trap,
  input wire logic reg_access_fault,
  input wire logic exec_hold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_idle;
    !(instr_valid || data_done || single_step || task_trap || avs_read || avs_write);
  endsequence
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |=> s_answer)
    else $error("bus answer not one cycle");
  chk_priv_fault: assert property (reg_access_fault |->
    !$past(avs_waitrequest) && !$past(real_mode) && $past(cpl) != 2'h0)
    else $error("access fault without cause");
  chk_priv_quiet: assert property (!avs_waitrequest && (real_mode || cpl == 2'h0) |=> !reg_access_fault)
    else $error("access fault while allowed");
  chk_fault_cause: assert property (exc1_fault |-> $past(instr_valid) || !$past(avs_waitrequest))
    else $error("fault without cause");
  // Single-step and task-switch traps share the trap output
  chk_trap_cause: assert property (exc1_trap |-> $past(data_done) || $past(single_step) || $past(task_trap))
    else $error("trap without completed transfer");
  chk_hold_set: assert property (data_valid && !data_done |=> exec_hold)
    else $error("hold missing");
  chk_hold_drop: assert property (!(data_valid && !data_done) |=> !exec_hold)
    else $error("hold stuck");
  chk_idle_quiet: assert property (s_idle ##1 s_idle |=> !exc1_fault && !exc1_trap && !reg_access_fault)
    else $error("event while idle");
endmodule
bind dbc_top dbc_top_properties u_dbc_top_properties (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
  .real_mode, .cpl, .instr_valid, .data_valid, .data_done, .single_step, .task_trap, .exc1_fault, .exc1_trap,
  .reg_access_fault, .exec_hold);

// ---- verif/tb.sv ----
// Self-checking bench for the breakpoint control block
`timescale 1ns/1ns
module tb;
  import dbc_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, real_mode, instr_valid, data_valid, data_done;
  logic data_write, single_step, task_trap, task_switch, handler_entry, exc1_fault, exc1_trap;
  logic reg_access_fault, exec_hold;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, instr_addr, rd;
  logic [3:0] avs_byteenable, data_be;
  logic [1:0] cpl;
  logic [29:0] data_dword_addr;
  int num_errors, total_checks, cycles;
  dbc_top u_dbc_top (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .real_mode, .cpl, .instr_valid, .instr_addr, .data_valid, .data_done,
    .data_dword_addr, .data_be, .data_write, .single_step, .task_trap, .task_switch, .handler_entry,
    .exc1_fault, .exc1_trap, .reg_access_fault, .exec_hold);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_evt(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t event %b expected %b", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, ZERO);
    chk_reg(rd, exp);
  endtask
  // One cycle of transfer in flight ahead of the completing cycle
  task automatic core(input logic iv, input logic [31:0] ia, input logic dd, input logic [3:0] be,
    input logic wr, input logic ef, input logic et);
    @(posedge clk);
    data_valid <= dd;
    @(posedge clk);
    instr_valid <= iv;
    instr_addr <= ia;
    data_dword_addr <= ia[31:2];
    data_be <= be;
    data_write <= wr;
    data_done <= dd;
    @(negedge clk);
    chk_evt(exec_hold, dd);
    @(posedge clk);
    instr_valid <= 1'b0;
    data_done <= 1'b0;
    data_valid <= 1'b0;
    @(negedge clk);
    chk_evt(exc1_fault, ef);
    chk_evt(exc1_trap, et);
  endtask
  task automatic pulse(input logic ss, input logic tt, input logic ts, input logic he);
    @(posedge clk);
    single_step <= ss;
    task_trap <= tt;
    task_switch <= ts;
    handler_entry <= he;
    @(posedge clk);
    {single_step, task_trap, task_switch, handler_entry} <= 4'h0;
  endtask
  task automatic t_reset;
    rreg(DBC_OFF_CONTROL, ZERO);
    rreg(DBC_OFF_STATUS, ZERO);
    rreg(5'h1c, ZERO);
    core(1'b1, ZERO, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    $display("done reset");
  endtask
  task automatic t_exec;
    bus(1'b1, DBC_OFF_ADDR0, 32'h1000_0005);
    bus(1'b1, DBC_OFF_CONTROL, 32'h0000_0001);
    core(1'b1, 32'h1000_0005, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
    rreg(DBC_OFF_STATUS, 32'h0000_0001);
    rreg(DBC_OFF_STATUS, 32'h0000_0001);
    bus(1'b1, DBC_OFF_STATUS, ZERO);
    core(1'b1, 32'h1000_0004, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    rreg(DBC_OFF_STATUS, ZERO);
    $display("done exec");
  endtask
  task automatic t_data;
    bus(1'b1, DBC_OFF_ADDR1, 32'h2000_0006);
    bus(1'b1, DBC_OFF_ADDR2, 32'h2000_0004);
    bus(1'b1, DBC_OFF_ADDR3, 32'h2000_0004);
    // Word rdwr on 1, disabled dword on 2, write-only byte on 3
    bus(1'b1, DBC_OFF_CONTROL, 32'h1f70_0088);
    core(1'b0, 32'h2000_0004, 1'b1, 4'h2, 1'b0, 1'b0, 1'b0);
    rreg(DBC_OFF_STATUS, ZERO);
    core(1'b0, 32'h2000_0004, 1'b1, 4'h8, 1'b0, 1'b0, 1'b1);
    rreg(DBC_OFF_STATUS, 32'h0000_0006);
    bus(1'b1, DBC_OFF_STATUS, ZERO);
    core(1'b0, 32'h2000_0004, 1'b1, 4'h1, 1'b1, 1'b0, 1'b1);
    rreg(DBC_OFF_STATUS, 32'h0000_000c);
    bus(1'b1, DBC_OFF_STATUS, ZERO);
    core(1'b0, 32'h2000_0004, 1'b1, 4'h1, 1'b0, 1'b0, 1'b0);
    rreg(DBC_OFF_STATUS, ZERO);
    $display("done data");
  endtask
  task automatic t_switch;
    bus(1'b1, DBC_OFF_CONTROL, 32'h0000_03ff);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    rreg(DBC_OFF_CONTROL, 32'h0000_02aa);
    $display("done switch");
  endtask
  task automatic t_guard;
    bus(1'b1, DBC_OFF_CONTROL, 32'h0000_2000);
    bus(1'b0, DBC_OFF_CONTROL, ZERO);
    chk_reg(rd, ZERO);
    @(negedge clk);
    chk_evt(exc1_fault, 1'b1);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    rreg(DBC_OFF_STATUS, 32'h0000_2000);
    rreg(DBC_OFF_CONTROL, ZERO);
    $display("done guard");
  endtask
  task automatic t_priv;
    real_mode <= 1'b0;
    cpl <= 2'h3;
    bus(1'b1, DBC_OFF_ADDR0, 32'hffff_ffff);
    @(negedge clk);
    chk_evt(reg_access_fault, 1'b1);
    bus(1'b0, DBC_OFF_ADDR0, ZERO);
    chk_reg(rd, ZERO);
    cpl <= 2'h0;
    rreg(DBC_OFF_ADDR0, 32'h1000_0005);
    real_mode <= 1'b1;
    $display("done priv");
  endtask
  task automatic t_flags;
    bus(1'b1, DBC_OFF_STATUS, ZERO);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    rreg(DBC_OFF_STATUS, 32'h0000_c000);
    bus(1'b1, DBC_OFF_STATUS, ZERO);
    rreg(DBC_OFF_STATUS, ZERO);
    $display("done flags");
  endtask
  initial begin
    {rst_b, avs_read, avs_write, instr_valid, data_valid, data_done, data_write} = 7'h00;
    {single_step, task_trap, task_switch, handler_entry, cpl} = 6'h00;
    real_mode = 1'b1;
    avs_address = 5'h00;
    avs_byteenable = 4'hf;
    {avs_writedata, instr_addr, data_dword_addr, data_be} = 98'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_exec;
    t_data;
    t_switch;
    t_guard;
    t_priv;
    t_flags;
    tally_and_finish;
  end
endmodule
